// file: micro_timer_sync_core_test.sv
// ------------------------------------------------------------------
// Self-checking bench for the timer core
// ------------------------------------------------------------------
module micro_timer_sync_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1; // Always ready: legal and keeps tasks short.
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sync_i, sync_o, cmp_clk_o, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pin_i, pin_o, pin_oe, peer_out_i;
  logic [31:0] ext_val = 32'ha5a5_0f0f; // Sensor levels seen on the pads.
  logic glitch = 1'b0;
  logic sync_req = 1'b0;
  int n_mismatch = 0;
  int total_checks = 0;
  mts_core dut_u (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i,
    .pin_o, .pin_oe, .peer_out_i, .sync_i, .sync_o, .cmp_clk_o, .irq
  );
  mts_far_model far_u (
    .clk, .pin_o, .pin_oe, .ext_val, .glitch, .sync_req, .pin_i,
    .peer_out_i, .sync_i
  );
  initial forever #10 clk = ~clk;
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic print_verdict;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compare one value; an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One edge of a bounded wait; running out ends the run.
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Signals read just after an edge still hold their sampled values.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = mts_pkg::RESP_OKAY);
    int n = 0;
    logic aw_d = 1'b0;
    logic w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_d && w_d))
    begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e,
                        input logic [1:0] er = mts_pkg::RESP_OKAY);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata & m, e);
    check(s_axi_rresp, er);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    axi_rd(mts_pkg::A_GCTRL, '1, mts_pkg::GC_RST);
    axi_rd(mts_pkg::A_PRESC, '1, mts_pkg::PRESC_RST);
  endtask
  // Two words in different banks, the last one, then one past the end.
  task automatic t_ram;
    logic [7:0] fa [3];
    fa = '{mts_pkg::A_RPROG, mts_pkg::A_RCTRL, mts_pkg::A_RDATA};
    axi_wr(mts_pkg::A_RADDR, {24'h0, mts_pkg::RAM_LAST});
    for (int i = 0; i < 3; i++)
      axi_wr(fa[i], 32'hc0de_0000 + i);
    axi_wr(mts_pkg::A_RADDR, 32'h2);
    for (int i = 0; i < 3; i++)
      axi_wr(fa[i], 32'h5a5a_0000 + i);
    axi_wr(mts_pkg::A_RADDR, {24'h0, mts_pkg::RAM_LAST});
    for (int i = 0; i < 3; i++)
      axi_rd(fa[i], '1, 32'hc0de_0000 + i);
    axi_wr(mts_pkg::A_RADDR, 32'ha0);
    axi_wr(mts_pkg::A_RDATA, 32'h1, mts_pkg::RESP_SLVERR);
    axi_wr(8'h40, 32'h0, mts_pkg::RESP_SLVERR);
    axi_rd(8'h40, '1, 32'h0, mts_pkg::RESP_SLVERR);
  endtask
  // Filter length 3 needs four equal samples after two sync stages.
  task automatic t_pins;
    axi_wr(mts_pkg::A_FILT, 32'h3);
    axi_wr(mts_pkg::A_DIR, 32'h8000_0001);
    check(pin_oe, 32'h8000_0001);
    idle(10);
    axi_rd(mts_pkg::A_PINS, '1, 32'h25a5_0f0e);
    axi_wr(mts_pkg::A_PINS, 32'h0);
    glitch <= 1'b1;
    idle(2);
    glitch <= 1'b0;
    idle(10);
    axi_rd(mts_pkg::A_PINS, '1, 32'h25a5_0f0e);
    axi_wr(mts_pkg::A_LPBK, 32'hffff_ffff);
    idle(10);
    axi_rd(mts_pkg::A_PINS, '1, 32'h0);
    axi_wr(mts_pkg::A_LPBK, 32'h0);
    axi_wr(mts_pkg::A_DIR, 32'h0);
    axi_wr(mts_pkg::A_DIAG, 32'h1);
    check(cmp_clk_o, 1'b1);
    idle(1);
    check(cmp_clk_o, 1'b0);
  endtask
  // Loop of 4 ticks of 2 clocks gives a sync pulse every 8 cycles.
  task automatic t_master;
    int n = 0;
    axi_wr(mts_pkg::A_MASK, 32'h2);
    axi_wr(mts_pkg::A_PRESC, 32'h0301);
    axi_wr(mts_pkg::A_GCTRL, 32'h0001_0001);
    do tick(n); while (sync_o !== 1'b1);
    do tick(n); while (sync_o !== 1'b1);
    n = 0;
    do tick(n); while (sync_o !== 1'b1);
    check(n, 8);
    check(irq, 1'b1);
    axi_wr(mts_pkg::A_MASK, 32'h0);
    check(irq, 1'b0);
    axi_wr(mts_pkg::A_GCTRL, 32'h0000_0001);
    idle(20);
    n = 0;
    repeat (30)
    begin
      @(posedge clk);
      if (sync_o !== 1'b0)
        n++;
    end
    check(n, 0);
    axi_wr(mts_pkg::A_STAT, 32'h7);
    axi_rd(mts_pkg::A_STAT, '1, 32'h0);
  endtask
  task automatic pulse_sync;
    sync_req <= 1'b1;
    @(posedge clk);
    sync_req <= 1'b0;
  endtask
  // A slave waits for the first sync, then loops on its own.
  task automatic t_slave;
    axi_wr(mts_pkg::A_MASK, 32'h4);
    idle(40);
    axi_rd(mts_pkg::A_STAT, 32'h2, 32'h0);
    pulse_sync();
    idle(40);
    axi_rd(mts_pkg::A_STAT, 32'h2, 32'h2);
    axi_wr(mts_pkg::A_STAT, 32'h7);
    idle(40);
    axi_rd(mts_pkg::A_STAT, 32'h6, 32'h2);
    check(irq, 1'b0);
    pulse_sync();
    idle(10);
    axi_rd(mts_pkg::A_STAT, 32'h4, 32'h4);
    check(irq, 1'b1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_ram();
    t_pins();
    t_master();
    t_slave();
    print_verdict();
  end
endmodule // micro_timer_sync_core_test

// file: mts_core.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
module mts_core #(
  parameter int unsigned NPIN = 32,
  parameter int unsigned CMP_CH = 31
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] peer_out_i,
  input wire logic sync_i,
  output logic sync_o,
  output logic cmp_clk_o,
  output logic irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    mts_pkg::mts_st_e st; // Sequencer state.
    logic master_act; // Role in force, changes at loop end.
    logic synced; // Slave has seen its first sync.
    logic [31:0] gctrl, presc, filt, dir, lpbk, diag, stat, mask;
    logic [31:0] raddr, stg_prog, stg_ctrl; // Memory access staging.
    logic [3:0][39:0][96:0] mem; // Bank, row; bit 96 is parity.
    logic [7:0] pc; // Instruction address.
    logic [24:0] acc; // Last virtual counter value.
    logic wb_en; // Write-back of a data field pending.
    logic [7:0] wb_addr;
    logic [31:0] wb_data;
    logic [NPIN-1:0] out, s1, s2, fq, edge_seen;
    logic [NPIN-1:0][7:0] fcnt; // Filter stability counters.
    logic [NPIN-1:0][6:0] hwc; // Per-pin fine counters.
    logic [7:0] hr_cnt, lr_cnt;
    logic sy1, sy2, sy_prev, sync;
    logic cmp;
    logic aw_v, w_v, bvalid, rvalid;
    logic [7:0] aw_a;
    logic [31:0] w_d, rdata;
    logic [3:0] w_s;
    logic [1:0] bresp, rresp;
  } mts_s;

  mts_s q_r; // Registered state.
  mts_s q_nxt; // Next state.

  // Byte-lane merge for AXI write strobes.
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Helper signals of the combinational process.
  logic [NPIN-1:0] raw; // Input seen by the filters.
  logic hr_tick, loop_end, resync, loop_start, perr_ev;
  logic [96:0] fw, bw; // Fetched word and bus-read word.
  logic [4:0] op, pin;
  logic [31:0] wv; // Merged write value.
  logic [31:0] clr; // Status bits cleared by software.
  logic [NPIN-1:0] chg;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    clr = '0;
    perr_ev = 1'b0;
    fw = '0;
    bw = '0;
    op = '0;
    pin = '0;
    wv = '0;
    // Pads pass two flops before anything reads them.
    q_nxt.s1 = pin_i;
    q_nxt.s2 = q_r.s1;
    q_nxt.sy1 = sync_i;
    q_nxt.sy2 = q_r.sy1;
    q_nxt.sy_prev = q_r.sy2;
    // Monitor mode watches the peer, else loopback or pad.
    if (q_r.diag[mts_pkg::DG_MON])
    begin
      raw = peer_out_i;
    end
    else
    begin
      raw = (q_r.lpbk[NPIN-1:0] & q_r.out) |
            (~q_r.lpbk[NPIN-1:0] & q_r.s2);
    end
    // A level is accepted only after it stays for filt+1 cycles.
    for (int i = 0; i < NPIN; i++)
    begin
      if (raw[i] == q_r.fq[i])
      begin
        q_nxt.fcnt[i] = '0;
      end
      else if (q_r.fcnt[i] >= q_r.filt[7:0])
      begin
        q_nxt.fq[i] = raw[i];
        q_nxt.fcnt[i] = '0;
      end
      else
      begin
        q_nxt.fcnt[i] = q_r.fcnt[i] + 8'h01;
      end
    end
    chg = q_nxt.fq ^ q_r.fq;
    // Prescalers: high-res tick, then loop-res boundary.
    hr_tick = (q_r.hr_cnt >= q_r.presc[7:0]);
    loop_end = hr_tick && (q_r.lr_cnt >= q_r.presc[15:8]);
    resync = !q_r.master_act && q_r.sy2 && !q_r.sy_prev;
    q_nxt.hr_cnt = hr_tick ? '0 : q_r.hr_cnt + 8'h01;
    if (hr_tick)
    begin
      q_nxt.lr_cnt = loop_end ? '0 : q_r.lr_cnt + 8'h01;
    end
    // Fine counters run until the pin's first edge in the loop.
    for (int i = 0; i < NPIN; i++)
    begin
      q_nxt.edge_seen[i] = q_r.edge_seen[i] | chg[i];
      if (hr_tick && !q_r.edge_seen[i] && !chg[i])
      begin
        q_nxt.hwc[i] = q_r.hwc[i] + 7'h01;
      end
    end
    // The role bit takes effect only at a loop boundary.
    if (loop_end)
    begin
      q_nxt.master_act = q_r.gctrl[mts_pkg::GC_MASTER];
    end
    // Master announces each loop boundary to the slave.
    q_nxt.sync = loop_end && q_r.master_act;
    if (resync)
    begin
      q_nxt.hr_cnt = '0;
      q_nxt.lr_cnt = '0;
      q_nxt.synced = 1'b1;
    end
    loop_start = q_r.gctrl[mts_pkg::GC_RUN] &&
                 ((loop_end && (q_r.master_act || q_r.synced)) ||
                  resync);
    // Only one writer per cycle: pending write-back goes first.
    if (q_r.wb_en)
    begin
      fw = q_r.mem[q_r.wb_addr[1:0]][q_r.wb_addr[7:2]];
      q_nxt.mem[q_r.wb_addr[1:0]][q_r.wb_addr[7:2]] =
        {^{fw[95:32], q_r.wb_data}, fw[95:32], q_r.wb_data};
      q_nxt.wb_en = 1'b0;
    end
    // Micromachine: one instruction per cycle until halt.
    if (loop_start)
    begin
      q_nxt.st = mts_pkg::MTS_RUN;
      q_nxt.pc = '0;
      q_nxt.edge_seen = '0;
      q_nxt.hwc = '0;
    end
    else if (q_r.st == mts_pkg::MTS_RUN)
    begin
      fw = q_r.mem[q_r.pc[1:0]][q_r.pc[7:2]];
      op = fw[68:64];
      pin = fw[76:72];
      if (^fw)
      begin
        perr_ev = 1'b1;
        q_nxt.st = mts_pkg::MTS_IDLE;
      end
      else if (q_r.wb_en && (q_r.wb_addr == q_r.pc))
      begin
        // Stall a cycle rather than read a stale data field.
      end
      else
      begin
        case (op)
          mts_pkg::OP_CNT:
          begin
            // Counter wraps to zero at its control-field limit.
            q_nxt.acc = (fw[24:0] >= fw[56:32]) ? '0 :
                        fw[24:0] + 25'h1;
            q_nxt.wb_en = 1'b1;
            q_nxt.wb_addr = q_r.pc;
            q_nxt.wb_data = {7'h00, q_nxt.acc};
          end
          mts_pkg::OP_CMP:
          begin
            q_nxt.out[pin] = (q_r.acc < fw[56:32]);
          end
          mts_pkg::OP_CAP:
          begin
            if (q_r.edge_seen[pin])
            begin
              q_nxt.wb_en = 1'b1;
              q_nxt.wb_addr = q_r.pc;
              q_nxt.wb_data = {q_r.acc, q_r.hwc[pin]};
            end
          end
          default:
          begin
            // Other valid opcodes have no effect here.
          end
        endcase
        q_nxt.pc = fw[95:88];
        if ((op == mts_pkg::OP_HALT) || (op >= mts_pkg::N_INSTR) ||
            (fw[95:88] > mts_pkg::RAM_LAST))
        begin
          q_nxt.st = mts_pkg::MTS_IDLE;
        end
      end
    end
    // AXI write channels are caught in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      q_nxt.aw_v = 1'b1;
      q_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      q_nxt.w_v = 1'b1;
      q_nxt.w_d = s_axi_wdata;
      q_nxt.w_s = s_axi_wstrb;
    end
    if (q_r.bvalid && s_axi_bready)
    begin
      q_nxt.bvalid = 1'b0;
    end
    // Write is performed when both halves are held and memory is free.
    if (q_r.aw_v && q_r.w_v && !q_r.bvalid && !q_r.wb_en)
    begin
      q_nxt.aw_v = 1'b0;
      q_nxt.w_v = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = mts_pkg::RESP_OKAY;
      if (q_r.aw_a[7:2] == mts_pkg::A_GCTRL[7:2])
      begin
        wv = wmerge(q_r.gctrl, q_r.w_d, q_r.w_s);
        q_nxt.gctrl = wv & mts_pkg::GC_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_PRESC[7:2])
      begin
        wv = wmerge(q_r.presc, q_r.w_d, q_r.w_s);
        q_nxt.presc = wv & mts_pkg::PRESC_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_FILT[7:2])
      begin
        wv = wmerge(q_r.filt, q_r.w_d, q_r.w_s);
        q_nxt.filt = wv & mts_pkg::FILT_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_DIR[7:2])
      begin
        q_nxt.dir = wmerge(q_r.dir, q_r.w_d, q_r.w_s);
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_PINS[7:2])
      begin
        // Readback only; writes are accepted and dropped.
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_LPBK[7:2])
      begin
        q_nxt.lpbk = wmerge(q_r.lpbk, q_r.w_d, q_r.w_s);
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_DIAG[7:2])
      begin
        wv = wmerge(q_r.diag, q_r.w_d, q_r.w_s);
        q_nxt.diag = wv & mts_pkg::DIAG_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_STAT[7:2])
      begin
        clr = wmerge(32'h0000_0000, q_r.w_d, q_r.w_s);
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_MASK[7:2])
      begin
        wv = wmerge(q_r.mask, q_r.w_d, q_r.w_s);
        q_nxt.mask = wv & mts_pkg::STAT_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_RADDR[7:2])
      begin
        wv = wmerge(q_r.raddr, q_r.w_d, q_r.w_s);
        q_nxt.raddr = wv & mts_pkg::RADDR_MASK;
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_RPROG[7:2])
      begin
        q_nxt.stg_prog = wmerge(q_r.stg_prog, q_r.w_d, q_r.w_s);
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_RCTRL[7:2])
      begin
        q_nxt.stg_ctrl = wmerge(q_r.stg_ctrl, q_r.w_d, q_r.w_s);
      end
      else if (q_r.aw_a[7:2] == mts_pkg::A_RDATA[7:2])
      begin
        // Commit the staged word with fresh even parity.
        wv = wmerge(32'h0000_0000, q_r.w_d, q_r.w_s);
        if (q_r.raddr[7:0] <= mts_pkg::RAM_LAST)
        begin
          q_nxt.mem[q_r.raddr[1:0]][q_r.raddr[7:2]] =
            {^{q_r.stg_prog, q_r.stg_ctrl, wv},
             q_r.stg_prog, q_r.stg_ctrl, wv};
        end
        else
        begin
          q_nxt.bresp = mts_pkg::RESP_SLVERR;
        end
      end
      else
      begin
        q_nxt.bresp = mts_pkg::RESP_SLVERR;
      end
    end
    // Reads answer one cycle after the address is taken.
    if (q_r.rvalid && s_axi_rready)
    begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = mts_pkg::RESP_OKAY;
      q_nxt.rdata = '0;
      if (q_r.raddr[7:0] <= mts_pkg::RAM_LAST)
      begin
        bw = q_r.mem[q_r.raddr[1:0]][q_r.raddr[7:2]];
      end
      if (s_axi_araddr[7:2] == mts_pkg::A_GCTRL[7:2])
      begin
        q_nxt.rdata = q_r.gctrl;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_PRESC[7:2])
      begin
        q_nxt.rdata = q_r.presc;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_FILT[7:2])
      begin
        q_nxt.rdata = q_r.filt;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_DIR[7:2])
      begin
        q_nxt.rdata = q_r.dir;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_PINS[7:2])
      begin
        q_nxt.rdata = 32'(q_r.fq);
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_LPBK[7:2])
      begin
        q_nxt.rdata = q_r.lpbk;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_DIAG[7:2])
      begin
        q_nxt.rdata = q_r.diag;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_STAT[7:2])
      begin
        q_nxt.rdata = q_r.stat;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_MASK[7:2])
      begin
        q_nxt.rdata = q_r.mask;
      end
      else if (s_axi_araddr[7:2] == mts_pkg::A_RADDR[7:2])
      begin
        q_nxt.rdata = q_r.raddr;
      end
      else if ((s_axi_araddr[7:2] >= mts_pkg::A_RPROG[7:2]) &&
               (s_axi_araddr[7:2] <= mts_pkg::A_RDATA[7:2]))
      begin
        // Field reads check the whole word's parity.
        perr_ev = perr_ev | (^bw);
        if (s_axi_araddr[7:2] == mts_pkg::A_RPROG[7:2])
        begin
          q_nxt.rdata = bw[95:64];
        end
        else if (s_axi_araddr[7:2] == mts_pkg::A_RCTRL[7:2])
        begin
          q_nxt.rdata = bw[63:32];
        end
        else
        begin
          q_nxt.rdata = bw[31:0];
        end
      end
      else
      begin
        q_nxt.rresp = mts_pkg::RESP_SLVERR;
      end
    end
    // Sticky status: a new event wins over a same-cycle clear.
    q_nxt.stat = ((q_r.stat & ~clr) |
                  {29'h0, resync, loop_start, perr_ev}) &
                 mts_pkg::STAT_MASK;
    // Comparator source: raw timer output or the pad return.
    q_nxt.cmp = q_r.diag[mts_pkg::DG_INT] ? q_r.out[CMP_CH] :
                q_r.s2[CMP_CH];
  end

  // ------------------------------------------------------------------
  // State register, synchronous active-low reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q_r <= '0;
      q_r.st <= mts_pkg::MTS_IDLE;
      q_r.gctrl <= mts_pkg::GC_RST;
      q_r.presc <= mts_pkg::PRESC_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = !q_r.aw_v && !q_r.bvalid;
  assign s_axi_wready = !q_r.w_v && !q_r.bvalid;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;
  assign pin_o = q_r.out;
  assign pin_oe = q_r.dir[NPIN-1:0];
  assign sync_o = q_r.sync;
  assign cmp_clk_o = q_r.cmp;
  assign irq = |(q_r.stat & q_r.mask);

endmodule // mts_core

// file: mts_core_monitor.sv
// ------------------------------------------------------------------
// Port-level checks on the timer core
// ------------------------------------------------------------------
module mts_core_monitor #(
  parameter int unsigned NPIN = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic sync_o,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so clock and reset are given once here.
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // A write answer stays put until the master takes it.
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp moved");
  // Read data may not change while it waits for the master.
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata moved");
  // A taken read is answered on the very next cycle.
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  // No new write is accepted while an answer is pending.
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write open");
  // A write taken whole is answered within a short bound.
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write late");
  // The core leaves reset as a slave, so it sends no sync at once.
  property p_slv_boot;
    $rose(rst_b) |-> !sync_o [*3];
  endproperty
  a_slv_boot: assert property (p_slv_boot) else $error("sync at boot");
  // An unmapped read answers an error with zero data.
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40
      |=> s_axi_rresp == mts_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad read");
  // Pins are released and quiet when reset lifts.
  property p_boot_pins;
    $rose(rst_b) |-> pin_oe == '0 && pin_o == '0 && !irq;
  endproperty
  a_boot_pins: assert property (p_boot_pins) else $error("pins busy");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_sync: cover property (sync_o);
endmodule // mts_core_monitor

bind mts_core mts_core_monitor #(.NPIN(NPIN)) mon_u (
  .clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_o, .pin_oe,
  .sync_o, .irq
);

// file: mts_far_model.sv
// ------------------------------------------------------------------
// Far side: sensor pads and the peer timer's sync line
// ------------------------------------------------------------------
module mts_far_model (
  input wire logic clk,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_val,
  input wire logic glitch,
  input wire logic sync_req,
  output logic [31:0] pin_i,
  output logic [31:0] peer_out_i,
  output logic sync_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] sync_cnt_r = 2'h0; // Cycles left in the sync pulse.
  logic [31:0] peer_r = 32'h5a5a_a5a5; // Peer outputs, toggled each cycle.
  // Enabled pins carry the core's drive; the rest carry the sensor level.
  // Sensor levels move only when the bench asks, far apart in time.
  assign pin_i = (pin_oe & pin_o) |
    (~pin_oe & (ext_val ^ {30'h0, glitch, 1'b0}));
  assign peer_out_i = peer_r;
  assign sync_i = sync_cnt_r != 2'h0;
  // The peer stretches its sync pulse so the core's synchroniser sees it.
  always @(posedge clk)
  begin
    peer_r <= ~peer_r;
    if (sync_req)
      sync_cnt_r <= 2'h3;
    else if (sync_cnt_r != 2'h0)
      sync_cnt_r <= sync_cnt_r - 2'h1;
  end
endmodule // mts_far_model

// file: mts_pkg.sv
package mts_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_GCTRL = 8'h00; // Run and clock role.
  localparam logic [7:0] A_PRESC = 8'h04; // High-res and loop-res dividers.
  localparam logic [7:0] A_FILT = 8'h08; // Input suppression length.
  localparam logic [7:0] A_DIR = 8'h0c; // Pin direction, 1 = output.
  localparam logic [7:0] A_PINS = 8'h10; // Filtered pin readback.
  localparam logic [7:0] A_LPBK = 8'h14; // Per-pin loopback enable.
  localparam logic [7:0] A_DIAG = 8'h18; // Monitor and comparator path.
  localparam logic [7:0] A_STAT = 8'h1c; // Sticky events, write one clears.
  localparam logic [7:0] A_MASK = 8'h20; // Interrupt mask.
  localparam logic [7:0] A_RADDR = 8'h24; // Instruction memory address.
  localparam logic [7:0] A_RPROG = 8'h28; // Program field.
  localparam logic [7:0] A_RCTRL = 8'h2c; // Control field.
  localparam logic [7:0] A_RDATA = 8'h30; // Data field, write commits.

  // ------------------------------------------------------------------
  // Field positions, masks and reset values
  // ------------------------------------------------------------------
  localparam int GC_RUN = 0;
  localparam int GC_MASTER = 16;
  localparam logic [31:0] GC_MASK = 32'h0001_0001;
  localparam logic [31:0] GC_RST = 32'h0000_0000;
  localparam logic [31:0] PRESC_MASK = 32'h0000_ffff;
  localparam logic [31:0] PRESC_RST = 32'h0000_1f00;
  localparam logic [31:0] FILT_MASK = 32'h0000_00ff;
  localparam logic [31:0] DIAG_MASK = 32'h0000_0003;
  localparam int DG_INT = 0;
  localparam int DG_MON = 1;
  localparam logic [31:0] STAT_MASK = 32'h0000_0007;
  localparam int ST_PERR = 0;
  localparam int ST_LOOP = 1;
  localparam int ST_SYNC = 2;
  localparam logic [31:0] RADDR_MASK = 32'h0000_00ff;

  // ------------------------------------------------------------------
  // Micromachine geometry and opcodes
  // ------------------------------------------------------------------
  localparam int RAM_WORDS = 160;
  localparam int N_BANKS = 4;
  localparam int BANK_ROWS = 40;
  localparam int VC_W = 25;
  localparam int HW_W = 7;
  localparam logic [4:0] N_INSTR = 5'h1e;
  localparam logic [4:0] OP_HALT = 5'h00;
  localparam logic [4:0] OP_CNT = 5'h01;
  localparam logic [4:0] OP_CMP = 5'h02;
  localparam logic [4:0] OP_CAP = 5'h03;
  localparam logic [7:0] RAM_LAST = 8'h9f;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Micromachine sequencing states, one-hot.
  typedef enum logic [1:0] {
    MTS_IDLE = 2'b01,
    MTS_RUN = 2'b10
  } mts_st_e;

endpackage
